// [rtl/btts_pkg.sv]
// Constants, register map and types of the bus traffic tracer
package btts_pkg;
  localparam int NM = 8;
  localparam int MID_W = 3;
  localparam int AW = 8;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_ADDR_LO = 8'h04;
  localparam logic [AW-1:0] OFS_ADDR_HI = 8'h08;
  localparam logic [AW-1:0] OFS_GROUP0 = 8'h0C;
  localparam logic [AW-1:0] OFS_GROUP1 = 8'h10;
  localparam logic [AW-1:0] OFS_WIN_LEN = 8'h14;
  localparam logic [AW-1:0] OFS_TP0 = 8'h18;
  localparam logic [AW-1:0] OFS_TP1 = 8'h1C;
  localparam logic [AW-1:0] OFS_WAIT = 8'h20;
  localparam logic [AW-1:0] OFS_GRANT = 8'h24;
  localparam logic [AW-1:0] OFS_INT_STS = 8'h28;
  localparam logic [AW-1:0] OFS_INT_MASK = 8'h2C;
  // ****************************************
  // Control fields
  // ****************************************
  localparam int CTRL_W = 10;
  localparam int C_TRACE_EN = 0;
  localparam int C_DIR_FILT = 1;
  localparam int C_DIR_WRITE = 2;
  localparam int C_ADDR_FILT = 3;
  localparam int C_AUTO_EXP = 4;
  localparam int C_EXP_STATUS = 5;
  localparam int C_EXP_EVENT = 6;
  localparam int C_EXP_STATS = 7;
  localparam int C_XTRIG0 = 8;
  localparam int C_XTRIG1 = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam int INT_W = 2;
  localparam int I_WIN = 0;
  localparam int I_DROP = 1;
  localparam logic [31:0] WIN_LEN_RST = 32'h0000_0400;
  localparam logic [31:0] ADDR_HI_RST = 32'hFFFF_FFFF;
  localparam logic [1:0] EXP_LAST = 2'h3;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    TYPE_STATUS = 2'b00,
    TYPE_EVENT = 2'b01,
    TYPE_STATS = 2'b10
  } btts_msg_e;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXPORT = 1'b1
  } btts_exp_e;
endpackage

// [rtl/btts_top.sv]
// Bus traffic tracer with window statistics for one watched slave
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module btts_top
  import btts_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [AW-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [NM-1:0] MON_REQ_I,
  input wire logic MON_GNT_I,
  input wire logic [MID_W-1:0] MON_GNT_MID_I,
  input wire logic [31:0] MON_ADDR_I,
  input wire logic MON_WRITE_I,
  input wire logic [15:0] MON_BYTES_I,
  input wire logic MON_DONE_I,
  input wire logic [MID_W-1:0] MON_DONE_MID_I,
  input wire logic TRIG_START_I,
  input wire logic TRIG_STOP_I,
  output logic XTRIG0_O,
  output logic XTRIG1_O,
  output logic TRACE_VALID_O,
  output logic [1:0] TRACE_TYPE_O,
  output logic [31:0] TRACE_DATA_O,
  input wire logic TRACE_READY_I,
  output logic IRQ_O
);
  // ****************************************
  // Trigger pin synchronisers
  // ****************************************
  logic [1:0] start_sync_q;
  logic [1:0] stop_sync_q;
  logic start_dly_q;
  logic stop_dly_q;
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      start_sync_q <= 2'h0;
      stop_sync_q <= 2'h0;
      start_dly_q <= 1'b0;
      stop_dly_q <= 1'b0;
    end else begin
      start_sync_q <= {start_sync_q[0], TRIG_START_I};
      stop_sync_q <= {stop_sync_q[0], TRIG_STOP_I};
      start_dly_q <= start_sync_q[1];
      stop_dly_q <= stop_sync_q[1];
    end
  end
  wire start_pulse = start_sync_q[1] & ~start_dly_q;
  wire stop_pulse = stop_sync_q[1] & ~stop_dly_q;

  // ****************************************
  // APB decode
  // ****************************************
  logic [CTRL_W-1:0] ctrl_q;
  logic [CTRL_W-1:0] ctrl_d;
  logic [31:0] addr_lo_q;
  logic [31:0] addr_hi_q;
  logic [NM-1:0] grp0_q;
  logic [NM-1:0] grp1_q;
  logic [31:0] win_len_q;
  logic [31:0] lat_tp0_q;
  logic [31:0] lat_tp1_q;
  logic [31:0] lat_wait_q;
  logic [31:0] lat_gnt_q;
  logic [INT_W-1:0] sts_q;
  logic [INT_W-1:0] sts_d;
  logic [INT_W-1:0] mask_q;
  logic [31:0] prdata_q;

  wire apb_setup = PSEL_I & ~PENABLE_I;
  wire apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
  wire sel_ctrl = PADDR_I == OFS_CTRL;
  wire sel_alo = PADDR_I == OFS_ADDR_LO;
  wire sel_ahi = PADDR_I == OFS_ADDR_HI;
  wire sel_g0 = PADDR_I == OFS_GROUP0;
  wire sel_g1 = PADDR_I == OFS_GROUP1;
  wire sel_win = PADDR_I == OFS_WIN_LEN;
  wire sel_tp0 = PADDR_I == OFS_TP0;
  wire sel_tp1 = PADDR_I == OFS_TP1;
  wire sel_wait = PADDR_I == OFS_WAIT;
  wire sel_gnt = PADDR_I == OFS_GRANT;
  wire sel_sts = PADDR_I == OFS_INT_STS;
  wire sel_mask = PADDR_I == OFS_INT_MASK;
  wire addr_hit = sel_ctrl | sel_alo | sel_ahi | sel_g0 | sel_g1 | sel_win | sel_tp0 |
                  sel_tp1 | sel_wait | sel_gnt | sel_sts | sel_mask;
  wire [31:0] rd_mux = sel_ctrl ? {{(32-CTRL_W){1'b0}}, ctrl_q} :
                       sel_alo ? addr_lo_q :
                       sel_ahi ? addr_hi_q :
                       sel_g0 ? {{(32-NM){1'b0}}, grp0_q} :
                       sel_g1 ? {{(32-NM){1'b0}}, grp1_q} :
                       sel_win ? win_len_q :
                       sel_tp0 ? lat_tp0_q :
                       sel_tp1 ? lat_tp1_q :
                       sel_wait ? lat_wait_q :
                       sel_gnt ? lat_gnt_q :
                       sel_sts ? {{(32-INT_W){1'b0}}, sts_q} :
                       sel_mask ? {{(32-INT_W){1'b0}}, mask_q} : 32'h0;
  // Zero wait states; read data is captured in the setup cycle
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_hit;
  assign PRDATA_O = prdata_q;

  always_comb begin
    ctrl_d = ctrl_q;
    if (apb_wr && sel_ctrl) begin
      ctrl_d = PWDATA_I[CTRL_W-1:0];
    end
    if (start_pulse) begin
      ctrl_d[C_TRACE_EN] = 1'b1;
    end else if (stop_pulse) begin
      ctrl_d[C_TRACE_EN] = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      ctrl_q <= CTRL_RST;
      addr_lo_q <= 32'h0;
      addr_hi_q <= ADDR_HI_RST;
      grp0_q <= '0;
      grp1_q <= '0;
      win_len_q <= WIN_LEN_RST;
      mask_q <= '0;
      prdata_q <= 32'h0;
    end else begin
      ctrl_q <= ctrl_d;
      if (apb_wr && sel_alo) addr_lo_q <= PWDATA_I;
      if (apb_wr && sel_ahi) addr_hi_q <= PWDATA_I;
      if (apb_wr && sel_g0) grp0_q <= PWDATA_I[NM-1:0];
      if (apb_wr && sel_g1) grp1_q <= PWDATA_I[NM-1:0];
      if (apb_wr && sel_win) win_len_q <= PWDATA_I;
      if (apb_wr && sel_mask) mask_q <= PWDATA_I[INT_W-1:0];
      if (apb_setup) prdata_q <= rd_mux;
    end
  end

  // ****************************************
  // Qualifier filters and attribute table
  // ****************************************
  // direction and address range
  wire dir_ok = ~ctrl_q[C_DIR_FILT] | (MON_WRITE_I == ctrl_q[C_DIR_WRITE]);
  wire addr_ok = ~ctrl_q[C_ADDR_FILT] | ((MON_ADDR_I >= addr_lo_q) & (MON_ADDR_I <= addr_hi_q));
  wire gnt_qual = dir_ok & addr_ok;

  // Completion carries no address, so the grant-time verdict is kept per master
  logic [NM-1:0] tab_qual_q;
  logic [NM-1:0] tab_wr_q;
  logic [26:0] tab_addr_q [NM];
  genvar gi;
  generate
    for (gi = 0; gi < NM; gi++) begin : g_tab
      wire hit = MON_GNT_I && (MON_GNT_MID_I == MID_W'(gi));
      always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
          tab_qual_q[gi] <= 1'b0;
          tab_wr_q[gi] <= 1'b0;
          tab_addr_q[gi] <= 27'h0;
        end else if (hit) begin
          tab_qual_q[gi] <= gnt_qual;
          tab_wr_q[gi] <= MON_WRITE_I;
          tab_addr_q[gi] <= MON_ADDR_I[26:0];
        end
      end
    end
  endgenerate

  wire ev_arb = MON_GNT_I & gnt_qual;
  wire ev_done = MON_DONE_I & tab_qual_q[MON_DONE_MID_I];

  // ****************************************
  // Statistics counters
  // ****************************************
  logic win_exp;
  btts_window_timer u_timer (
    .clk_i(CORE_CLK_I),
    .rst_i(RESET_I),
    .restart_i(apb_wr & sel_win),
    .len_i(win_len_q),
    .expire_o(win_exp)
  );

  logic [31:0] run_tp0_q;
  logic [31:0] run_tp1_q;
  logic [31:0] run_wait_q;
  logic [31:0] run_gnt_q;
  wire [31:0] bytes = {16'h0, MON_BYTES_I};
  // bytes counted at initiation, per group
  wire [31:0] inc_tp0 = (ev_arb && grp0_q[MON_GNT_MID_I]) ? bytes : 32'h0;
  wire [31:0] inc_tp1 = (ev_arb && grp1_q[MON_GNT_MID_I]) ? bytes : 32'h0;
  wire [31:0] inc_wait = {31'h0, |MON_REQ_I};
  wire [31:0] inc_gnt = {31'h0, MON_GNT_I};
  wire [31:0] sum_tp0 = run_tp0_q + inc_tp0;
  wire [31:0] sum_tp1 = run_tp1_q + inc_tp1;
  wire [31:0] sum_wait = run_wait_q + inc_wait;
  wire [31:0] sum_gnt = run_gnt_q + inc_gnt;

  // latch on expiry and restart from zero
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      run_tp0_q <= 32'h0;
      run_tp1_q <= 32'h0;
      run_wait_q <= 32'h0;
      run_gnt_q <= 32'h0;
    end else begin
      run_tp0_q <= win_exp ? 32'h0 : sum_tp0;
      run_tp1_q <= win_exp ? 32'h0 : sum_tp1;
      run_wait_q <= win_exp ? 32'h0 : sum_wait;
      run_gnt_q <= win_exp ? 32'h0 : sum_gnt;
    end
  end

  // latched values change only at expiry
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      lat_tp0_q <= 32'h0;
      lat_tp1_q <= 32'h0;
      lat_wait_q <= 32'h0;
      lat_gnt_q <= 32'h0;
    end else if (win_exp) begin
      lat_tp0_q <= sum_tp0;
      lat_tp1_q <= sum_tp1;
      lat_wait_q <= sum_wait;
      lat_gnt_q <= sum_gnt;
    end
  end

  // ****************************************
  // Trace sink output
  // ****************************************
  btts_exp_e st_q;
  btts_exp_e st_d;
  logic [1:0] idx_q;
  logic [1:0] idx_d;
  logic sts_pend_q;
  logic tv_q;
  logic [1:0] tt_q;
  logic [31:0] td_q;
  logic [1:0] xtrig_q;

  wire trace_on = ctrl_q[C_TRACE_EN] & ctrl_q[C_EXP_EVENT];
  wire out_free = ~tv_q | TRACE_READY_I;
  wire exporting = st_q == ST_EXPORT;
  wire exp_go = win_exp & ctrl_q[C_AUTO_EXP] & ctrl_q[C_EXP_STATS];
  wire ev_want = trace_on & (ev_arb | ev_done);
  wire send_stat = exporting & out_free;
  wire send_ev = ev_want & out_free & ~exporting;
  wire send_sts = sts_pend_q & out_free & ~exporting & ~ev_want;
  wire ev_drop = ev_want & (~send_ev | (ev_arb & ev_done));
  wire sts_chg = (ctrl_d[C_TRACE_EN] != ctrl_q[C_TRACE_EN]) & ctrl_q[C_EXP_STATUS];
  wire [31:0] ev_rec = ev_done ?
      {1'b1, tab_wr_q[MON_DONE_MID_I], MON_DONE_MID_I, tab_addr_q[MON_DONE_MID_I]} :
      {1'b0, MON_WRITE_I, MON_GNT_MID_I, MON_ADDR_I[26:0]};
  wire [31:0] stat_word = (idx_q == 2'h0) ? lat_tp0_q :
                          (idx_q == 2'h1) ? lat_tp1_q :
                          (idx_q == 2'h2) ? lat_wait_q : lat_gnt_q;

  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    case (st_q)
      ST_IDLE: begin
        idx_d = 2'h0;
        if (exp_go) st_d = ST_EXPORT;
      end
      ST_EXPORT: begin
        if (exp_go) begin
          idx_d = 2'h0;
        end else if (send_stat) begin
          idx_d = idx_q + 2'h1;
          if (idx_q == EXP_LAST) st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
        idx_d = 2'h0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      st_q <= ST_IDLE;
      idx_q <= 2'h0;
      sts_pend_q <= 1'b0;
      tv_q <= 1'b0;
      tt_q <= TYPE_STATUS;
      td_q <= 32'h0;
      xtrig_q <= 2'h0;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      sts_pend_q <= sts_chg | (sts_pend_q & ~send_sts);
      xtrig_q <= {ctrl_q[C_XTRIG1], ctrl_q[C_XTRIG0]} & {2{ev_arb | ev_done}};
      if (send_stat) begin
        tv_q <= 1'b1;
        tt_q <= TYPE_STATS;
        td_q <= stat_word;
      end else if (send_ev) begin
        tv_q <= 1'b1;
        tt_q <= TYPE_EVENT;
        td_q <= ev_rec;
      end else if (send_sts) begin
        tv_q <= 1'b1;
        tt_q <= TYPE_STATUS;
        td_q <= {31'h0, ctrl_q[C_TRACE_EN]};
      end else if (TRACE_READY_I) begin
        tv_q <= 1'b0;
      end
    end
  end
  assign TRACE_VALID_O = tv_q;
  assign TRACE_TYPE_O = tt_q;
  assign TRACE_DATA_O = td_q;
  assign XTRIG0_O = xtrig_q[0];
  assign XTRIG1_O = xtrig_q[1];

  // ****************************************
  // Interrupt status
  // ****************************************
  // sticky window and drop flags, set beats clear
  assign sts_d = (sts_q & ~((apb_wr && sel_sts) ? PWDATA_I[INT_W-1:0] : {INT_W{1'b0}})) |
                 {ev_drop, win_exp};
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      sts_q <= '0;
    end else begin
      sts_q <= sts_d;
    end
  end
  assign IRQ_O = |(sts_q & mask_q);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  sequence s_export_go;
    win_exp && ctrl_q[C_AUTO_EXP] && ctrl_q[C_EXP_STATS];
  endsequence
  sequence s_grp0_add;
    MON_GNT_I && gnt_qual && grp0_q[MON_GNT_MID_I] && !win_exp;
  endsequence

  chk_arb_event_out: assert property (send_ev |=> tv_q && tt_q == TYPE_EVENT)
    else $error("event record not presented");
  chk_filter_blocks_tp: assert property (MON_GNT_I && !gnt_qual && !win_exp
    |=> run_tp0_q == $past(run_tp0_q))
    else $error("filtered transfer counted");
  chk_tp0_adds_bytes: assert property (s_grp0_add
    |=> run_tp0_q == $past(run_tp0_q) + {16'h0, $past(MON_BYTES_I)})
    else $error("throughput did not add bytes");
  chk_tp1_group_off: assert property (MON_GNT_I && !grp1_q[MON_GNT_MID_I] && !win_exp
    |=> run_tp1_q == $past(run_tp1_q))
    else $error("non-member counted in group one");
  chk_wait_count_up: assert property ((|MON_REQ_I) && !win_exp
    |=> run_wait_q == $past(run_wait_q) + 32'h1)
    else $error("wait counter missed a cycle");
  chk_grant_count_up: assert property (MON_GNT_I && !win_exp
    |=> run_gnt_q == $past(run_gnt_q) + 32'h1)
    else $error("grant counter missed a grant");
  chk_win_restart: assert property (win_exp |=> run_gnt_q == 32'h0 && sts_q[I_WIN])
    else $error("window expiry did not restart");
  chk_win_irq_out: assert property (win_exp && mask_q[I_WIN] |=> IRQ_O)
    else $error("window interrupt missing");
  chk_export_begin: assert property (s_export_go |=> exporting && idx_q == 2'h0)
    else $error("auto export not started");
  chk_xtrig_pulse: assert property ((ev_arb || ev_done) && ctrl_q[C_XTRIG0] |=> XTRIG0_O)
    else $error("cross trigger not driven");
  chk_start_sets_en: assert property (start_pulse |=> ctrl_q[C_TRACE_EN])
    else $error("start trigger ignored");
  chk_stop_clears_en: assert property (stop_pulse && !start_pulse |=> !ctrl_q[C_TRACE_EN])
    else $error("stop trigger ignored");
  chk_latch_hold: assert property (!win_exp |=> $stable(lat_tp0_q) && $stable(lat_gnt_q))
    else $error("latched statistics moved between expiries");
endmodule // btts_top

// [rtl/btts_window_timer.sv]
// Repeating fixed-length measurement window timer
`timescale 1ns/1ps
module btts_window_timer
  import btts_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic restart_i,
  input wire logic [31:0] len_i,
  output logic expire_o
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  wire last_cycle = (len_i == 32'h0) || (cnt_q >= len_i - 32'h1);

  assign expire_o = last_cycle & ~restart_i;
  assign cnt_d = (last_cycle | restart_i) ? 32'h0 : cnt_q + 32'h1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // btts_window_timer

// [testbench/btts_bus_model.sv]
// Bus masters, trigger sources and trace sink around the tracer
`timescale 1ns/1ps
module btts_bus_model
  import btts_pkg::*;
(
  input wire logic clk_i,
  output logic [NM-1:0] req_o,
  output logic gnt_o,
  output logic [MID_W-1:0] gnt_mid_o,
  output logic [31:0] addr_o,
  output logic write_o,
  output logic [15:0] bytes_o,
  output logic done_o,
  output logic [MID_W-1:0] done_mid_o,
  output logic start_o,
  output logic stop_o,
  input wire logic valid_i,
  input wire logic [1:0] type_i,
  input wire logic [31:0] data_i,
  output logic ready_o
);
  logic slow = 1'b0;
  logic [33:0] got[$];
  initial begin
    {req_o, gnt_o, gnt_mid_o, addr_o, write_o, bytes_o} = '0;
    {done_o, done_mid_o, start_o, stop_o, ready_o} = '0;
  end
  // A slow sink accepts on every other cycle only
  always @(posedge clk_i) begin
    ready_o <= slow ? ~ready_o : 1'b1;
    if (valid_i === 1'b1 && ready_o === 1'b1) got.push_back({type_i, data_i});
  end
  // One access: wait, grant, completion; released fields never keep their value
  task automatic xfer(input int mid, input logic [31:0] a, input logic w,
                      input logic [15:0] n, input int wt);
    if (wt > 0) begin
      req_o[mid] <= 1'b1;
      repeat (wt) @(posedge clk_i);
      req_o[mid] <= 1'b0;
    end
    gnt_o <= 1'b1;
    gnt_mid_o <= mid[MID_W-1:0];
    addr_o <= a;
    write_o <= w;
    bytes_o <= n;
    @(posedge clk_i);
    gnt_o <= 1'b0;
    gnt_mid_o <= ~gnt_mid_o;
    addr_o <= ~a;
    write_o <= ~w;
    bytes_o <= ~n;
    repeat (2) @(posedge clk_i);
    done_o <= 1'b1;
    done_mid_o <= mid[MID_W-1:0];
    @(posedge clk_i);
    done_o <= 1'b0;
    done_mid_o <= ~done_mid_o;
  endtask
  task automatic trig(input logic stop);
    if (stop) stop_o <= 1'b1;
    else start_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    start_o <= 1'b0;
    stop_o <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
endmodule // btts_bus_model

// [testbench/tb.sv]
// Self-checking bench for the bus traffic tracer
`timescale 1ns/1ps
module tb;
  import btts_pkg::*;
  logic clk, rst, psel, pen, pwr, pready, pslverr, slv;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rdata, maddr, tdata;
  logic [NM-1:0] req;
  logic gnt, mwr, done, tstart, tstop, x0, x1, tvalid, tready, irq;
  logic [MID_W-1:0] gmid, dmid;
  logic [15:0] mbytes;
  logic [1:0] ttype;
  int err_total = 0;
  int check_count = 0;
  int x0n, x1n, x0b, x1b;
  logic [AW-1:0] ra[9] = '{OFS_CTRL, OFS_ADDR_LO, OFS_ADDR_HI, OFS_GROUP0, OFS_GROUP1,
                           OFS_WIN_LEN, OFS_TP0, OFS_INT_STS, OFS_INT_MASK};
  logic [31:0] rv[9] = '{32'h0, 32'h0, ADDR_HI_RST, 32'h0, 32'h0, WIN_LEN_RST, 32'h0,
                         32'h0, 32'h0};
  btts_top dut_u (.CORE_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .MON_REQ_I(req), .MON_GNT_I(gnt),
    .MON_GNT_MID_I(gmid), .MON_ADDR_I(maddr), .MON_WRITE_I(mwr), .MON_BYTES_I(mbytes),
    .MON_DONE_I(done), .MON_DONE_MID_I(dmid), .TRIG_START_I(tstart), .TRIG_STOP_I(tstop),
    .XTRIG0_O(x0), .XTRIG1_O(x1), .TRACE_VALID_O(tvalid), .TRACE_TYPE_O(ttype),
    .TRACE_DATA_O(tdata), .TRACE_READY_I(tready), .IRQ_O(irq));
  btts_bus_model bm_u (.clk_i(clk), .req_o(req), .gnt_o(gnt), .gnt_mid_o(gmid),
    .addr_o(maddr), .write_o(mwr), .bytes_o(mbytes), .done_o(done), .done_mid_o(dmid),
    .start_o(tstart), .stop_o(tstop), .valid_i(tvalid), .type_i(ttype), .data_i(tdata),
    .ready_o(tready));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic stall();
    err_total++;
    $display("BAD %0t wait ran out", $time);
    give_verdict();
  endtask
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Holds the request until pready is seen high at a rising edge; one idle cycle follows
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdata = prdata;
    slv = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1) stall();
    @(posedge clk);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk({2'b00, rdata}, {2'b00, e});
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (irq !== 1'b1 && n < 200);
    if (irq !== 1'b1) stall();
    @(posedge clk);
  endtask
  task automatic win_chk(input logic [31:0] t0, t1, wt, gr);
    wait_irq();
    rd_chk(OFS_INT_STS, 32'h1);
    rd_chk(OFS_TP0, t0);
    rd_chk(OFS_TP1, t1);
    rd_chk(OFS_WAIT, wt);
    rd_chk(OFS_GRANT, gr);
  endtask
  always @(posedge clk) begin
    if (x0 === 1'b1) x0n++;
    if (x1 === 1'b1) x1n++;
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    stall();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst, psel, pen, pwr, paddr, pwdata} = '1;
    {psel, pen, pwr, paddr, pwdata} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 9; i++) rd_chk(ra[i], rv[i]);
    wr(OFS_TP0, 32'h0000_005A);
    rd_chk(OFS_TP0, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk({1'b0, slv, rdata}, {2'b01, 32'h0});
    $display("test reset done");
    wr(OFS_GROUP0, 32'h05);
    wr(OFS_GROUP1, 32'h06);
    wr(OFS_ADDR_LO, 32'h100);
    wr(OFS_ADDR_HI, 32'h1FF);
    wr(OFS_CTRL, 32'h008);
    wr(OFS_INT_MASK, 32'h1);
    wr(OFS_WIN_LEN, 32'd60);
    wr(OFS_INT_STS, 32'h3);
    bm_u.xfer(0, 32'h100, 1'b1, 16'd16, 1);
    bm_u.xfer(1, 32'h1FF, 1'b0, 16'd8, 2);
    bm_u.xfer(2, 32'h180, 1'b1, 16'd4, 0);
    bm_u.xfer(0, 32'h200, 1'b1, 16'd32, 3);
    bm_u.xfer(3, 32'h150, 1'b0, 16'd64, 1);
    win_chk(32'd20, 32'd12, 32'd7, 32'd5);
    repeat (20) @(posedge clk);
    rd_chk(OFS_TP0, 32'd20);
    wr(OFS_INT_STS, 32'h1);
    win_chk(32'd0, 32'd0, 32'd0, 32'd0);
    wr(OFS_INT_MASK, 32'h0);
    wr(OFS_INT_STS, 32'h1);
    repeat (61) @(posedge clk);
    @(negedge clk);
    chk({33'h0, irq}, 34'h0);
    @(posedge clk);
    rd_chk(OFS_INT_STS, 32'h1);
    wr(OFS_INT_MASK, 32'h1);
    $display("test window done");
    wr(OFS_CTRL, 32'h006);
    wr(OFS_WIN_LEN, 32'd60);
    wr(OFS_INT_STS, 32'h3);
    bm_u.xfer(0, 32'h100, 1'b1, 16'd16, 0);
    bm_u.xfer(0, 32'h104, 1'b0, 16'd8, 0);
    win_chk(32'd16, 32'd0, 32'd0, 32'd2);
    $display("test direction done");
    wr(OFS_CTRL, 32'h341);
    bm_u.got.delete();
    x0b = x0n;
    x1b = x1n;
    bm_u.xfer(5, 32'h0000_0ABC, 1'b1, 16'd4, 0);
    repeat (4) @(posedge clk);
    chk(34'(bm_u.got.size()), 34'd2);
    chk(bm_u.got[0], {2'b01, 5'b01101, 27'hABC});
    chk(bm_u.got[1], {2'b01, 5'b11101, 27'hABC});
    chk({32'h0, x0n != x0b, x1n != x1b}, 34'h3);
    wr(OFS_CTRL, 32'h149);
    x0b = x0n;
    bm_u.xfer(5, 32'h0000_0ABC, 1'b1, 16'd4, 0);
    repeat (4) @(posedge clk);
    chk({32'(bm_u.got.size()), x0n != x0b, 1'b0}, {32'd2, 2'b00});
    $display("test events done");
    wr(OFS_CTRL, 32'h020);
    bm_u.got.delete();
    bm_u.trig(1'b0);
    rd_chk(OFS_CTRL, 32'h021);
    bm_u.trig(1'b1);
    rd_chk(OFS_CTRL, 32'h020);
    chk(bm_u.got[0], {2'b00, 32'h1});
    chk(bm_u.got[1], {2'b00, 32'h0});
    $display("test triggers done");
    wr(OFS_WIN_LEN, 32'd60);
    wr(OFS_CTRL, 32'h090);
    wr(OFS_INT_STS, 32'h3);
    bm_u.slow <= 1'b1;
    bm_u.got.delete();
    bm_u.xfer(2, 32'h180, 1'b1, 16'd4, 1);
    wait_irq();
    for (int n = 0; n < 100 && bm_u.got.size() < 4; n++) @(posedge clk);
    chk(bm_u.got[0], {2'b10, 32'd4});
    chk(bm_u.got[1], {2'b10, 32'd4});
    chk(bm_u.got[2], {2'b10, 32'd1});
    chk(bm_u.got[3], {2'b10, 32'd1});
    $display("test export done");
    give_verdict();
  end
endmodule // tb
